// ---- common/tx_desc_defines.vh ----
// Constants for the transmit descriptor engine: register map, descriptor fields and event codes.
`ifndef TX_DESC_DEFINES_VH
`define TX_DESC_DEFINES_VH
// ====================================================================
// Register byte offsets on the AXI4-Lite slave.
`define REG_CTRL_OFS 8'h00
`define REG_DESC_ADDR_OFS 8'h04
`define REG_STATUS_OFS 8'h08
`define REG_IRQ_STATUS_OFS 8'h0C
`define REG_IRQ_MASK_OFS 8'h10
`define REG_LAST_WORD0_OFS 8'h14
`define REG_LAST_WORD1_OFS 8'h18
`define REG_LAST_WORD2_OFS 8'h1C
`define REG_BYTES_SENT_OFS 8'h20
// ====================================================================
// Descriptor word zero fields.
`define DESC_VALID_BIT 31
`define DESC_LIST_END_BIT 30
`define FRAME_POS_HI_BIT 29
`define FRAME_POS_LO_BIT 28
`define FRAME_ERROR_BIT 27
`define TX_ABORT_BIT 8
`define EVENT_MSB 3
// ====================================================================
// Frame position codes.
`define FPOS_MIDDLE 2'h0
`define FPOS_END 2'h1
`define FPOS_START 2'h2
`define FPOS_SINGLE 2'h3
// ====================================================================
// Descriptor word one fields and word spacing.
`define BYTE_COUNT_MSB 31
`define BYTE_COUNT_LSB 16
`define DESC_WORD_STRIDE 32'h0000_0004
`define DESC_BYTES 32'h0000_000C
// ====================================================================
// Interrupt status bit positions.
`define IRQ_DONE_BIT 0
`define IRQ_ABORT_BIT 1
`define IRQ_HALT_BIT 2
`define IRQ_WIDTH 3
// ====================================================================
// Reset values.
`define CTRL_RESET 32'h0000_0000
`define MASK_RESET 3'h0
`endif

// ---- core/tx_desc_mem_port.v ----
// Simple memory request sequencer that issues one word read or write and waits for its acknowledge.
`timescale 1ns/10ps
`default_nettype none
module tx_desc_mem_port
(
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire start,
  input wire start_we,
  input wire [31:0] start_addr,
  input wire [31:0] start_wdata,
  output wire busy,
  output reg done_ff,
  output reg [31:0] rdata_ff,
  output reg mem_req_ff,
  output reg mem_we_ff,
  output reg [31:0] mem_addr_ff,
  output reg [31:0] mem_wdata_ff,
  input wire mem_ack,
  input wire [31:0] mem_rdata
);
  // ====================================================================
  // Request holds until acknowledged; done pulses one cycle with the data.
  assign busy = mem_req_ff;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= 32'h0000_0000;
      mem_wdata_ff <= 32'h0000_0000;
      rdata_ff <= 32'h0000_0000;
      done_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      done_ff <= 1'b0;
      if (mem_req_ff && mem_ack)
      begin
        mem_req_ff <= 1'b0;
        done_ff <= 1'b1;
        rdata_ff <= mem_rdata;
      end
      else if (!mem_req_ff && start)
      begin
        mem_req_ff <= 1'b1;
        mem_we_ff <= start_we;
        mem_addr_ff <= start_addr;
        mem_wdata_ff <= start_wdata;
      end
    end
  end
endmodule
`default_nettype wire

// ---- core/tx_desc_engine.v ----
// Transmit descriptor engine: fetches descriptors, streams buffers, writes status back.
//
// Overview of operation
// - Position 00 middle, 01 end, 10 start, 11 single.
// - Frame error set on abort or events.
// - Abort bit set whenever any event set.
// - Status bits 3..0 mirror the four events.
// - Aborted frames count as partially sent.
// - Word one high half gives byte count.
// - Word one low half always zero.
// - Engine clears valid bit after transfer.
// - Write-back clears valid, stores status.
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "tx_desc_defines.vh"
module tx_desc_engine
(
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire mem_req,
  output wire mem_we,
  output wire [31:0] mem_addr,
  output wire [31:0] mem_wdata,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  output reg tx_valid_ff,
  output reg [31:0] tx_data_ff,
  output reg [2:0] tx_last_bytes_ff,
  output reg tx_sof_ff,
  output reg tx_eof_ff,
  input wire tx_ready,
  input wire tx_done,
  input wire [3:0] tx_events,
  output wire irq
);
  // ====================================================================
  // States, one-hot.
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_FETCH = 7'h02;
  localparam [6:0] ST_CHECK = 7'h04;
  localparam [6:0] ST_DATA = 7'h08;
  localparam [6:0] ST_SEND = 7'h10;
  localparam [6:0] ST_WAIT = 7'h20;
  localparam [6:0] ST_WBACK = 7'h40;

  reg [6:0] state_ff;
  reg [1:0] word_idx_ff;
  reg [31:0] word0_ff;
  reg [31:0] word1_ff;
  reg [31:0] word2_ff;
  reg [31:0] desc_addr_ff;
  reg [31:0] list_base_ff;
  reg [15:0] remain_ff;
  reg [31:0] buf_ptr_ff;
  reg [3:0] events_ff;
  reg [31:0] bytes_sent_ff;
  reg run_ff;
  reg partial_ff;
  reg [`IRQ_WIDTH-1:0] irq_status_ff;
  reg [`IRQ_WIDTH-1:0] irq_mask_ff;
  reg [`IRQ_WIDTH-1:0] irq_set;
  reg mp_start;
  reg mp_we;
  reg [31:0] mp_addr;
  reg [31:0] mp_wdata;
  wire mp_busy;
  wire mp_done;
  wire [31:0] mp_rdata;
  wire [1:0] frame_pos;
  wire pos_starts;
  wire pos_ends;
  wire [3:0] event_bits;
  wire abort_bit;
  wire [31:0] wb_word0;

  // ====================================================================
  // Memory port.
  tx_desc_mem_port u_mem
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .start(mp_start),
    .start_we(mp_we),
    .start_addr(mp_addr),
    .start_wdata(mp_wdata),
    .busy(mp_busy),
    .done_ff(mp_done),
    .rdata_ff(mp_rdata),
    .mem_req_ff(mem_req),
    .mem_we_ff(mem_we),
    .mem_addr_ff(mem_addr),
    .mem_wdata_ff(mem_wdata),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  // ====================================================================
  // Frame position decode: bit 1 marks a start, bit 0 marks an end.
  assign frame_pos = word0_ff[`FRAME_POS_HI_BIT:`FRAME_POS_LO_BIT];
  assign pos_starts = (frame_pos == `FPOS_START) || (frame_pos == `FPOS_SINGLE);
  assign pos_ends = (frame_pos == `FPOS_END) || (frame_pos == `FPOS_SINGLE);

  // Status word built for write-back; reserved positions always zero.
  assign event_bits = events_ff;
  assign abort_bit = |event_bits;
  assign wb_word0 = {1'b0, word0_ff[`DESC_LIST_END_BIT:`FRAME_POS_LO_BIT],
                     abort_bit | (|event_bits), 18'h0_0000, abort_bit, 4'h0, event_bits};

  // ====================================================================
  // Request to the memory port, chosen by state.
  always @*
  begin
    mp_start = 1'b0;
    mp_we = 1'b0;
    mp_addr = desc_addr_ff;
    mp_wdata = 32'h0000_0000;
    case (state_ff)
      ST_FETCH:
      begin
        mp_start = !mp_busy && !mp_done;
        mp_addr = desc_addr_ff + {28'h000_0000, word_idx_ff, 2'b00};
      end
      ST_DATA:
      begin
        mp_start = !mp_busy && !mp_done && !tx_valid_ff && !partial_ff;
        mp_addr = {buf_ptr_ff[31:2], 2'b00}; // Low bits dropped since buffers are longword aligned.
      end
      ST_WBACK:
      begin
        mp_start = !mp_busy && !mp_done;
        mp_we = 1'b1;
        mp_wdata = wb_word0;
      end
      default:
      begin
        mp_start = 1'b0;
      end
    endcase
  end

  // ====================================================================
  // Descriptor sequencer.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= ST_IDLE;
      word_idx_ff <= 2'h0;
      word0_ff <= 32'h0000_0000;
      word1_ff <= 32'h0000_0000;
      word2_ff <= 32'h0000_0000;
      desc_addr_ff <= 32'h0000_0000;
      remain_ff <= 16'h0000;
      buf_ptr_ff <= 32'h0000_0000;
      events_ff <= 4'h0;
      bytes_sent_ff <= 32'h0000_0000;
      partial_ff <= 1'b0;
      tx_valid_ff <= 1'b0;
      tx_data_ff <= 32'h0000_0000;
      tx_last_bytes_ff <= 3'h0;
      tx_sof_ff <= 1'b0;
      tx_eof_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (tx_valid_ff && tx_ready)
        tx_valid_ff <= 1'b0;
      case (state_ff)
        ST_IDLE:
        begin
          if (run_ff)
          begin
            desc_addr_ff <= list_base_ff;
            word_idx_ff <= 2'h0;
            state_ff <= ST_FETCH;
          end
        end
        ST_FETCH:
        begin
          if (mp_done)
          begin
            word_idx_ff <= word_idx_ff + 2'h1;
            if (word_idx_ff == 2'h0)
              word0_ff <= mp_rdata;
            else if (word_idx_ff == 2'h1)
              word1_ff <= {mp_rdata[`BYTE_COUNT_MSB:`BYTE_COUNT_LSB], 16'h0000};
            else
            begin
              word2_ff <= mp_rdata;
              state_ff <= ST_CHECK;
            end
          end
        end
        ST_CHECK:
        begin
          // An invalid descriptor halts the engine without write-back.
          if (!word0_ff[`DESC_VALID_BIT])
            state_ff <= ST_IDLE;
          else
          begin
            remain_ff <= word1_ff[`BYTE_COUNT_MSB:`BYTE_COUNT_LSB];
            buf_ptr_ff <= word2_ff;
            if (pos_starts)
            begin
              events_ff <= 4'h0;
              partial_ff <= 1'b0;
            end
            tx_sof_ff <= pos_starts;
            state_ff <= (word1_ff[`BYTE_COUNT_MSB:`BYTE_COUNT_LSB] == 16'h0000) ? ST_WAIT : ST_DATA;
          end
        end
        ST_DATA:
        begin
          // Once an abort is seen the rest of the buffer is skipped, but only after a read in flight
          // has returned, so that its answer is never mistaken for the write-back acknowledge.
          if (partial_ff && !mp_busy)
            state_ff <= ST_WAIT;
          else if (mp_done)
          begin
            tx_data_ff <= mp_rdata;
            tx_valid_ff <= 1'b1;
            tx_last_bytes_ff <= (remain_ff > 16'h0004) ? 3'h4 : remain_ff[2:0];
            tx_eof_ff <= pos_ends && (remain_ff <= 16'h0004);
            state_ff <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          if (tx_valid_ff && tx_ready)
          begin
            tx_sof_ff <= 1'b0;
            buf_ptr_ff <= buf_ptr_ff + `DESC_WORD_STRIDE;
            if (remain_ff <= 16'h0004)
            begin
              bytes_sent_ff <= bytes_sent_ff + {16'h0000, remain_ff};
              remain_ff <= 16'h0000;
              state_ff <= ST_WAIT;
            end
            else
            begin
              bytes_sent_ff <= bytes_sent_ff + 32'h0000_0004;
              remain_ff <= remain_ff - 16'h0004;
              state_ff <= ST_DATA;
            end
          end
        end
        ST_WAIT:
        begin
          // Start and middle pieces, and frame ends already aborted, write back at once; other frame ends wait for the MAC result.
          if (!pos_ends || partial_ff)
            state_ff <= ST_WBACK;
          else if (tx_done)
          begin
            events_ff <= tx_events;
            partial_ff <= |tx_events;
            state_ff <= ST_WBACK;
          end
        end
        ST_WBACK:
        begin
          if (mp_done)
          begin
            word_idx_ff <= 2'h0;
            desc_addr_ff <= word0_ff[`DESC_LIST_END_BIT] ? list_base_ff : desc_addr_ff + `DESC_BYTES;
            state_ff <= run_ff ? ST_FETCH : ST_IDLE;
          end
        end
        default:
        begin
          state_ff <= ST_IDLE;
        end
      endcase
      if (tx_done && (state_ff != ST_WAIT) && (|tx_events))
      begin
        events_ff <= events_ff | tx_events;
        partial_ff <= 1'b1;
      end
    end
  end

  // ====================================================================
  // Interrupt events: completed frame, aborted frame, halt on invalid.
  always @*
  begin
    irq_set = {`IRQ_WIDTH{1'b0}};
    irq_set[`IRQ_DONE_BIT] = (state_ff == ST_WBACK) && mp_done && pos_ends && !partial_ff;
    irq_set[`IRQ_ABORT_BIT] = (state_ff == ST_WBACK) && mp_done && partial_ff;
    irq_set[`IRQ_HALT_BIT] = (state_ff == ST_CHECK) && !word0_ff[`DESC_VALID_BIT];
  end
  assign irq = |(irq_status_ff & irq_mask_ff);

  // ====================================================================
  // AXI4-Lite slave, one write and one read outstanding.
  reg aw_got_ff;
  reg w_got_ff;
  reg [7:0] aw_addr_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;
  reg [31:0] rd_mux;
  reg rd_hit;
  wire wr_fire;
  wire [31:0] wmask;
  wire [31:0] ctrl_word;

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
  assign ctrl_word = {31'h0000_0000, run_ff};

  // Read decode; unmapped offsets answer SLVERR with zero data.
  always @*
  begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `REG_CTRL_OFS: rd_mux = ctrl_word;
      `REG_DESC_ADDR_OFS: rd_mux = list_base_ff;
      `REG_STATUS_OFS: rd_mux = {25'h000_0000, state_ff};
      `REG_IRQ_STATUS_OFS: rd_mux = {29'h0000_0000, irq_status_ff};
      `REG_IRQ_MASK_OFS: rd_mux = {29'h0000_0000, irq_mask_ff};
      `REG_LAST_WORD0_OFS: rd_mux = word0_ff;
      `REG_LAST_WORD1_OFS: rd_mux = word1_ff;
      `REG_LAST_WORD2_OFS: rd_mux = word2_ff;
      `REG_BYTES_SENT_OFS: rd_mux = bytes_sent_ff;
      default:
      begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Bus state and writable registers; a new event beats a clearing write.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
      run_ff <= 1'b0;
      list_base_ff <= 32'h0000_0000;
      irq_status_ff <= {`IRQ_WIDTH{1'b0}};
      irq_mask_ff <= `MASK_RESET;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_hit ? 2'h0 : 2'h2;
      end
      else if (rvalid_ff && s_axi_rready)
        rvalid_ff <= 1'b0;
      if (state_ff == ST_CHECK && !word0_ff[`DESC_VALID_BIT])
        run_ff <= 1'b0;
      irq_status_ff <= irq_status_ff | irq_set;
      if (wr_fire)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= 2'h0;
        case (aw_addr_ff)
          `REG_CTRL_OFS: if (w_strb_ff[0]) run_ff <= w_data_ff[0];
          `REG_DESC_ADDR_OFS: list_base_ff <= (list_base_ff & ~wmask) | (w_data_ff & wmask);
          `REG_IRQ_STATUS_OFS: irq_status_ff <= (irq_status_ff & ~(w_data_ff[`IRQ_WIDTH-1:0] & wmask[`IRQ_WIDTH-1:0]))
                                                | irq_set;
          `REG_IRQ_MASK_OFS: if (w_strb_ff[0]) irq_mask_ff <= w_data_ff[`IRQ_WIDTH-1:0];
          `REG_STATUS_OFS, `REG_LAST_WORD0_OFS, `REG_LAST_WORD1_OFS, `REG_LAST_WORD2_OFS, `REG_BYTES_SENT_OFS:
            bresp_ff <= 2'h0;
          default: bresp_ff <= 2'h2;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/tx_desc_engine_props.sv ----
// Port-level assertions for the transmit descriptor engine.
`timescale 1ns/10ps
`default_nettype none
module tx_desc_engine_props
(
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire mem_ack,
  input wire tx_valid_ff,
  input wire [31:0] tx_data_ff,
  input wire [2:0] tx_last_bytes_ff,
  input wire tx_ready
);
  // ==========
  // Every check runs on the bus clock and is quiet during reset.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Write-back words must carry a cleared valid bit and consistent error flags.
  AST_WB_VALID_CLEAR: assert property (mem_req && mem_we |-> !mem_wdata[31])
    else $error("write-back leaves the valid bit set");
  AST_WB_ERROR_FLAG: assert property (mem_req && mem_we |->
    mem_wdata[27] == (mem_wdata[8] || mem_wdata[3:0] != 4'h0))
    else $error("frame error flag does not match abort and event bits");
  AST_WB_ABORT_FLAG: assert property (mem_req && mem_we |-> mem_wdata[8] == (mem_wdata[3:0] != 4'h0))
    else $error("abort bit does not follow the event bits");
  AST_WB_RESERVED: assert property (mem_req && mem_we |->
    mem_wdata[26:9] == 18'h0 && mem_wdata[7:4] == 4'h0)
    else $error("write-back sets reserved status bits");
  // A pending memory request must not move before it is answered.
  AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before acknowledge");
  // Stream words stand until taken and never claim more than a word.
  AST_TX_HOLD: assert property (tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_data_ff))
    else $error("stream word dropped or changed while stalled");
  AST_TX_BYTES: assert property (tx_valid_ff |-> tx_last_bytes_ff != 3'h0 && tx_last_bytes_ff <= 3'h4)
    else $error("stream word byte count out of range");
  // Read data follows an accepted read address one cycle later.
  AST_R_LATENCY: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule
bind tx_desc_engine tx_desc_engine_props props_inst
(
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .tx_valid_ff(tx_valid_ff),
  .tx_data_ff(tx_data_ff), .tx_last_bytes_ff(tx_last_bytes_ff), .tx_ready(tx_ready)
);
`default_nettype wire

// ---- verification/desc_mem.sv ----
// System memory model holding descriptors and transmit buffers, answering after a variable lag.
`timescale 1ns/10ps
`default_nettype none
module desc_mem
(
  input wire aclk,
  input wire aresetn,
  input wire [1:0] lag,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  // ==========
  // Storage and answer timing.
  logic [31:0] mem [0:127];
  logic [1:0] wait_ff;
  // One acknowledge per request; data flips outside the answer so a stale word never looks fresh.
  always @(posedge aclk)
  begin
    mem_rdata <= ~mem_rdata;
    if (!aresetn || mem_ack)
    begin
      mem_ack <= 1'b0;
      wait_ff <= 2'h0;
      if (!aresetn)
        mem_rdata <= 32'h0;
    end
    else if (mem_req && wait_ff >= lag)
    begin
      mem_ack <= 1'b1;
      if (mem_we)
        mem[mem_addr[8:2]] <= mem_wdata;
      else
        mem_rdata <= mem[mem_addr[8:2]];
    end
    else if (mem_req)
      wait_ff <= wait_ff + 2'h1;
  end
endmodule
`default_nettype wire

// ---- verification/eth_tx_descriptor_format_tb_top.sv ----
// Self-checking bench for the transmit descriptor engine with a memory model and a scripted MAC.
`timescale 1ns/10ps
`default_nettype none
`include "tx_desc_defines.vh"
module eth_tx_descriptor_format_tb_top;
  // ==========
  // Stimulus, observation and reference state.
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, tx_ready = 1'b0, tx_done = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd_val, bufa;
  logic [3:0] tx_events = 4'h0, ev;
  logic [1:0] lag = 2'h0, rd_resp, pos;
  logic [4:0] code;
  wire awready, wready, bvalid, arready, rvalid, mem_req, mem_we, mem_ack, tx_valid, tx_sof, tx_eof, irq;
  wire [1:0] bresp, rresp;
  wire [2:0] tx_bytes;
  wire [31:0] rdata, mem_addr, mem_wdata, mem_rdata, tx_data;
  integer num_errors = 0, checked = 0, cycles = 0, seed = 32'h3D36, done_wait = 0, n, total = 0;
  logic [7:0] exp_q[$];
  logic [4:0] word_q[$];
  logic [3:0] ev_q[$];
  logic [31:0] exp_wb[8];

  tx_desc_engine tx_desc_engine_inst
  (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .tx_valid_ff(tx_valid), .tx_data_ff(tx_data),
    .tx_last_bytes_ff(tx_bytes), .tx_sof_ff(tx_sof), .tx_eof_ff(tx_eof), .tx_ready(tx_ready),
    .tx_done(tx_done), .tx_events(tx_events), .irq(irq)
  );
  desc_mem desc_mem_inst
  (
    .aclk(aclk), .aresetn(aresetn), .lag(lag), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );

  // 100 MHz clock.
  initial
  begin
    forever #5 aclk = ~aclk;
  end

  // ==========
  // Comparison, verdict and bus tasks.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Handshakes are judged at the rising edge itself, so a release never races the slave's own sampling.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      aw_ok = aw_ok || (awvalid && awready);
      w_ok = w_ok || (wvalid && wready);
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
    end
    while (!bvalid) @(posedge aclk);
    check("bresp", {30'h0, bresp}, 32'h0);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (!rvalid) @(posedge aclk);
    rd_val = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    axi_rd(a);
    check(what, rd_val, e);
    check("rresp", {30'h0, rd_resp}, {30'h0, r});
  endtask

  // Scripted MAC: random back-pressure, a late frame-end pulse, and per-word stream comparison.
  always @(posedge aclk)
  begin
    tx_ready <= ($random(seed) & 3) != 0;
    lag <= 2'($random(seed));
    tx_done <= done_wait == 1;
    tx_events <= (done_wait == 1) ? ev_q.pop_front() : ~tx_events;
    done_wait <= (tx_valid && tx_ready && tx_eof) ? 3 : (done_wait > 0 ? done_wait - 1 : 0);
    if (tx_valid && tx_ready)
    begin
      code = word_q.pop_front();
      check("tx flags", {27'h0, tx_sof, tx_eof, tx_bytes}, {27'h0, code});
      for (int i = 0; i < 4; i++)
        if (i < code[2:0])
          check("tx byte", {24'h0, tx_data[8*i+:8]}, {24'h0, exp_q.pop_front()});
    end
  end

  // Eight descriptors need well under a thousand cycles; the ceiling leaves ample margin.
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors = num_errors + 1;
      test_done;
    end
  end

  // ==========
  // Main sequence: five single frames, one split frame, then a halt on the reused base descriptor.
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      pos = (k < 5) ? `FPOS_SINGLE : (k == 5) ? `FPOS_START : (k == 6) ? `FPOS_MIDDLE : `FPOS_END;
      ev = (k < 4) ? 4'h1 << k : 4'h0;
      n = 1 + ($random(seed) & 7);
      total = total + n;
      bufa = 32'h100 + 32 * k;
      desc_mem_inst.mem[3*k] = {1'b1, k == 7, pos, 28'h0};
      desc_mem_inst.mem[3*k+1] = {n[15:0], 16'h0};
      desc_mem_inst.mem[3*k+2] = bufa;
      desc_mem_inst.mem[bufa[8:2]] = $random(seed);
      desc_mem_inst.mem[bufa[8:2]+1] = $random(seed);
      for (int b = 0; b < n; b++)
        exp_q.push_back(desc_mem_inst.mem[bufa[8:2] + b / 4][8*(b%4)+:8]);
      for (int w = 0; w < (n + 3) / 4; w++)
        word_q.push_back({w == 0 && pos[1], w == (n - 1) / 4 && pos[0], n - 4 * w > 4 ? 3'h4 : 3'(n - 4 * w)});
      if (pos[0])
        ev_q.push_back(ev);
      exp_wb[k] = {1'b0, k == 7, pos, |ev, 18'h0, |ev, 4'h0, ev};
    end
    rd_chk("ctrl reset", `REG_CTRL_OFS, `CTRL_RESET, 2'h0);
    rd_chk("mask reset", `REG_IRQ_MASK_OFS, {29'h0, `MASK_RESET}, 2'h0);
    rd_chk("unmapped", 8'hFC, 32'h0, 2'h2);
    axi_wr(`REG_DESC_ADDR_OFS, 32'h0);
    axi_wr(`REG_CTRL_OFS, 32'h1);
    rd_val = 32'h1;
    while (rd_val[0] !== 1'b0)
      axi_rd(`REG_CTRL_OFS);
    for (int k = 0; k < 8; k++)
      check("desc word0", desc_mem_inst.mem[3*k], exp_wb[k]);
    check("bytes left", exp_q.size(), 0);
    check("words left", word_q.size(), 0);
    rd_chk("bytes sent", `REG_BYTES_SENT_OFS, total, 2'h0);
    rd_chk("irq status", `REG_IRQ_STATUS_OFS, {29'h0, 3'h7}, 2'h0);
    check("irq masked", {31'h0, irq}, 32'h0);
    axi_wr(`REG_IRQ_MASK_OFS, 32'h1 << `IRQ_ABORT_BIT);
    @(negedge aclk);
    check("irq on", {31'h0, irq}, 32'h1);
    axi_wr(`REG_IRQ_STATUS_OFS, 32'h1 << `IRQ_ABORT_BIT);
    @(negedge aclk);
    check("irq off", {31'h0, irq}, 32'h0);
    rd_chk("irq cleared", `REG_IRQ_STATUS_OFS, {29'h0, 3'h5}, 2'h0);
    test_done;
  end
endmodule
`default_nettype wire
